// >>> srw_pkg.sv
`default_nettype none
package srw_pkg;
  // Time base: one tick per microsecond at the 50 MHz clock.
  localparam int CLK_MHZ = 50;
  localparam int TICK_NS = 1000;
  localparam int CLK_NS = 1000 / CLK_MHZ;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  // Interval scaling in ms per microfarad of timing capacitance.
  localparam int HOLD_MS_PER_UF = 5000;
  localparam int WDOG_MS_PER_UF = 5000;
  localparam int STOP_HOLD_MS_PER_UF = 4900;
  localparam int WRST_MS_PER_UF = 100;
  // Default timing capacitance in nanofarads.
  localparam int CAP_NF_DEF = 20;
  // Least supply dropout width and least service pulse width, in us.
  localparam int DROPOUT_US = 8;
  localparam int SERVICE_MIN_US = 3;
  localparam int DROPOUT_CYC = (DROPOUT_US * TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 24;
  localparam int DRP_W = 12;

  // Convert a ms-per-uF figure and capacitance in nF to microsecond ticks.
  function automatic logic [23:0] ticks_of(input int ms_per_uf, input int cap_nf);
    ticks_of = 24'(ms_per_uf * cap_nf);
  endfunction : ticks_of
endpackage : srw_pkg
`default_nettype wire

// >>> srw_tick.sv
`default_nettype none
// Divides the clock down to a one-cycle tick, the unit of the hold, watchdog and reset intervals.
module srw_tick #(
  parameter int DIV = srw_pkg::TICK_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  output logic tick_out
);
  logic [15:0] cnt_r;
  logic wrap;

  assign wrap = (cnt_r == 16'(DIV - 1));

  // Free-running divider; frozen with the clock enable.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 16'h0000;
      tick_out <= 1'b0;
    end else if (en_in) begin
      cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
      tick_out <= wrap;
    end
  end
endmodule : srw_tick
`default_nettype wire

// >>> srw_watchdog.sv
`default_nettype none
// Notes on behaviour
// - Reset output goes low as soon as the supply is minimally operating.
// - Supply above upper detect level while in reset starts the hold timing.
// - Reset releases after hold interval, 5000 ms per uF.
// - After power-on release the ramp restarts and monitoring begins.
// - Falling service edge during rising ramp switches to discharge.
// - Discharge end returns to rising ramp; repeats while edges arrive.
// - No edge before rising ramp ends asserts reset; 5000 ms per uF.
// - Watchdog reset lasts 100 ms per uF, then monitoring restarts.
// - Supply below lower detect level asserts reset at once.
// - Only a dip lasting the least dropout width restarts full hold timing.
// - After supply recovers, release one hold interval later; every brownout of at least the dropout width.
// - Reset stays low during power-down until supply is gone.
// - Stop input low suppresses watchdog reset pulses.
// - Ramp keeps running while stopped; release during discharge asserts reset.
// - Power-up with stop low releases after 4900 ms per uF.
// - Service edges during hold keep reset low until activity stops.
// - Monitoring interval is timed from the end of the discharge that a falling service edge starts.
module srw_watchdog #(
  parameter int CAP_NF = srw_pkg::CAP_NF_DEF,
  parameter int DIV = srw_pkg::TICK_CYC,
  parameter int DROP_CYC = srw_pkg::DROPOUT_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic supply_high_in,
  input wire logic supply_low_in,
  input wire logic service_pulse_in,
  input wire logic watchdog_stop_n_in,
  output logic sys_reset_n_out,
  output logic wdog_active_out
);
  typedef enum logic [3:0] {
    SRW_RESET = 4'b0001,
    SRW_HOLD = 4'b0010,
    SRW_CHARGE = 4'b0100,
    SRW_DISCH = 4'b1000
  } srw_state_t;

  // Interval lengths in ticks.
  localparam logic [23:0] HOLD_T = srw_pkg::ticks_of(srw_pkg::HOLD_MS_PER_UF, CAP_NF);
  localparam logic [23:0] WDOG_T = srw_pkg::ticks_of(srw_pkg::WDOG_MS_PER_UF, CAP_NF);
  localparam logic [23:0] SHLD_T = srw_pkg::ticks_of(srw_pkg::STOP_HOLD_MS_PER_UF, CAP_NF);
  localparam logic [23:0] WRST_T = srw_pkg::ticks_of(srw_pkg::WRST_MS_PER_UF, CAP_NF);

  logic rs1_r, rs2_r, rst_n;
  logic tick;
  srw_state_t state_r, state_nxt;
  logic [23:0] tmr_r, tmr_nxt;
  logic [11:0] drop_r;
  logic svc_d_r;
  logic stop_d_r;
  logic wrst_r, wrst_nxt;
  logic rst_out_nxt;
  logic stop_at_rise_r;
  logic svc_fall, stop_rel, drop_long, tmr_hit;
  logic [23:0] hold_len, tmr_inc;

  // Reset release through two flip-flops.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  assign rst_n = rs2_r;

  srw_tick #(.DIV(DIV)) u_tick (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .en_in(clk_en_in),
    .tick_out(tick)
  );

  // Edge and level decode of the pin inputs.
  assign svc_fall = svc_d_r & ~service_pulse_in;
  assign stop_rel = ~stop_d_r & watchdog_stop_n_in;
  assign drop_long = (drop_r >= 12'(DROP_CYC));
  assign tmr_inc = tick ? tmr_r + 24'h000001 : tmr_r;
  // shorter hold when powered up stopped
  assign hold_len = stop_at_rise_r ? SHLD_T : HOLD_T;

  // Ramp and phase sequencing.
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_inc;
    wrst_nxt = wrst_r;
    tmr_hit = 1'b0;
    unique case (state_r)
      SRW_RESET: begin
        tmr_nxt = 24'h000000;
        if (supply_high_in) begin
          state_nxt = SRW_HOLD;
        end
      end
      SRW_HOLD: begin
        if (svc_fall) begin
          tmr_nxt = 24'h000000;
        end else if (tmr_r >= hold_len) begin
          state_nxt = SRW_CHARGE;
          tmr_nxt = 24'h000000;
        end
      end
      SRW_CHARGE: begin
        // service edge starts discharge, timed from it
        if (svc_fall) begin
          state_nxt = SRW_DISCH;
          tmr_nxt = 24'h000000;
          wrst_nxt = 1'b0;
        end else if (tmr_r >= WDOG_T) begin
          tmr_hit = 1'b1;
          state_nxt = SRW_DISCH;
          tmr_nxt = 24'h000000;
          wrst_nxt = 1'b1;
        end
      end
      SRW_DISCH: begin
        // stop release during discharge asserts reset
        if (stop_rel) begin
          wrst_nxt = 1'b1;
        end
        if (tmr_r >= WRST_T) begin
          state_nxt = SRW_CHARGE;
          tmr_nxt = 24'h000000;
          wrst_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = SRW_RESET;
        tmr_nxt = 24'h000000;
      end
    endcase
    if (supply_low_in && drop_long) begin
      state_nxt = SRW_RESET;
      tmr_nxt = 24'h000000;
      wrst_nxt = 1'b0;
    end
  end

  assign rst_out_nxt = ~supply_low_in && (state_nxt == SRW_CHARGE || state_nxt == SRW_DISCH)
                       && !(wrst_nxt && watchdog_stop_n_in);

  // State registers, frozen by the clock enable.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SRW_RESET;
      tmr_r <= 24'h000000;
      wrst_r <= 1'b0;
      svc_d_r <= 1'b1; // Idle level of the pin, so no false edge follows reset.
      stop_d_r <= 1'b1;
      drop_r <= 12'h000;
      stop_at_rise_r <= 1'b0;
      sys_reset_n_out <= 1'b0;
      wdog_active_out <= 1'b0;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      wrst_r <= wrst_nxt;
      svc_d_r <= service_pulse_in;
      stop_d_r <= watchdog_stop_n_in;
      drop_r <= !supply_low_in ? 12'h000 : (drop_long ? drop_r : drop_r + 12'h001);
      if (state_r == SRW_RESET) begin
        stop_at_rise_r <= ~watchdog_stop_n_in;
      end
      sys_reset_n_out <= rst_out_nxt;
      wdog_active_out <= (state_nxt == SRW_CHARGE || state_nxt == SRW_DISCH);
    end
  end

  // Checks on the sequencing.
  // They watch only what the block drives; every one is gated by the clock enable.
  // brownout asserts reset
  brown_reset_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && supply_low_in |=> !sys_reset_n_out)
    else $error("Reset not asserted on low supply.");

  wdog_timeout_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && tmr_hit && watchdog_stop_n_in && !supply_low_in |=> !sys_reset_n_out)
    else $error("Watchdog timeout did not assert reset.");

  stop_masks_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && !watchdog_stop_n_in && !supply_low_in && state_nxt == SRW_DISCH
    |=> sys_reset_n_out)
    else $error("Reset pulse emitted while stopped.");

  svc_disch_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_CHARGE && svc_fall && !supply_low_in |=> sys_reset_n_out)
    else $error("Service discharge asserted reset.");

  hold_low_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_HOLD && svc_fall |=> !sys_reset_n_out)
    else $error("Reset released during service in hold.");

  wrst_end_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_DISCH && tmr_r >= WRST_T && !supply_low_in
    |=> sys_reset_n_out && state_r == SRW_CHARGE)
    else $error("Watchdog reset did not end.");

  hold_end_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_HOLD && !svc_fall && tmr_r >= hold_len && !supply_low_in
    |=> sys_reset_n_out)
    else $error("Hold end did not release reset.");

  // stop release in any discharge, service or timeout, asserts reset
  stop_rel_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_DISCH && stop_rel && tmr_r < WRST_T
    |=> !sys_reset_n_out)
    else $error("Stop release in discharge kept reset high.");

  hold_start_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_RESET && supply_high_in && !(supply_low_in && drop_long)
    |=> state_r == SRW_HOLD)
    else $error("Hold timing did not start.");

  rst_low_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && (state_nxt == SRW_RESET || state_nxt == SRW_HOLD) |=> !sys_reset_n_out)
    else $error("Reset high before monitoring began.");

  mon_start_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_HOLD && !svc_fall && tmr_r >= hold_len
    && !(supply_low_in && drop_long)
    |=> state_r == SRW_CHARGE && tmr_r == 24'h000000 && wdog_active_out)
    else $error("Monitoring did not start from zero.");

  svc_to_disch_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_CHARGE && svc_fall && !(supply_low_in && drop_long)
    |=> state_r == SRW_DISCH && tmr_r == 24'h000000)
    else $error("Service edge did not start discharge.");

  disch_end_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_DISCH && tmr_r >= WRST_T && !(supply_low_in && drop_long)
    |=> state_r == SRW_CHARGE && tmr_r == 24'h000000)
    else $error("Discharge did not return to the rising ramp.");

  no_early_reset_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_CHARGE && !svc_fall && tmr_r < WDOG_T && !supply_low_in
    |=> sys_reset_n_out && state_r == SRW_CHARGE)
    else $error("Reset asserted before the monitoring interval ended.");

  short_dip_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && supply_low_in && !drop_long && state_r == SRW_CHARGE && !svc_fall
    && tmr_r < WDOG_T
    |=> state_r == SRW_CHARGE)
    else $error("Short supply dip restarted the hold timing.");

  long_dip_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && supply_low_in && drop_long |=> state_r == SRW_RESET && !sys_reset_n_out)
    else $error("Long supply dip did not restart the hold timing.");

  off_low_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_RESET && !supply_high_in
    |=> !sys_reset_n_out && state_r == SRW_RESET)
    else $error("Reset released with the supply down.");

  stop_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_HOLD && stop_at_rise_r && !svc_fall && tmr_r >= SHLD_T
    && !supply_low_in
    |=> sys_reset_n_out)
    else $error("Stopped power-up hold did not release reset.");

  tick_pace_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clk_en_in && state_r == SRW_CHARGE && !svc_fall && tmr_r < WDOG_T
    && !(supply_low_in && drop_long)
    |=> tmr_r == $past(tmr_r) + {23'h000000, $past(tick)})
    else $error("Ramp timer moved off the time base.");

  // Scenario covers: timeout, service, brownout, stop release, service in hold.
  cov_timeout_c: cover property (@(posedge mclk_in) disable iff (!rst_n) tmr_hit);
  cov_service_c: cover property (@(posedge mclk_in) disable iff (!rst_n)
    state_r == SRW_CHARGE && svc_fall);
  cov_brown_c: cover property (@(posedge mclk_in) disable iff (!rst_n)
    state_r == SRW_CHARGE && supply_low_in && drop_long);
  cov_stop_rel_c: cover property (@(posedge mclk_in) disable iff (!rst_n)
    state_r == SRW_DISCH && stop_rel);
  cov_hold_svc_c: cover property (@(posedge mclk_in) disable iff (!rst_n)
    state_r == SRW_HOLD && svc_fall);
endmodule : srw_watchdog
`default_nettype wire

// >>> srw_host.sv
`default_nettype none
// Host side model: drives falling service edges at a fixed spacing while run_in is high.
module srw_host #(
  parameter int WIDTH = srw_pkg::SERVICE_MIN_US
) (
  input wire logic mclk_in,
  input wire logic run_in,
  input wire logic [15:0] gap_in,
  output logic service_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_r;
  // Changes land on the falling edge so the block samples settled levels.
  // pulse width kept; host idles unless the bench runs it.
  always @(negedge mclk_in) begin
    if (!run_in) begin
      cnt_r <= 16'h0000;
      service_pulse_out <= 1'b1;
    end else begin
      cnt_r <= (cnt_r == gap_in - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
      service_pulse_out <= !(int'(cnt_r) < WIDTH);
    end
  end
endmodule : srw_host
`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, sup_hi, sup_lo, stop_n, run, svc, rst_out, act;
  int n_fail = 0;
  int samples_checked = 0;
  int n;
  // Short counts so every interval fits the run: hold 5000, reset width 100.
  srw_watchdog #(.CAP_NF(1), .DIV(1), .DROP_CYC(8)) u_dut (.mclk_in(mclk),
    .rst_n_in(rst_n), .clk_en_in(1'b1), .supply_high_in(sup_hi), .supply_low_in(sup_lo),
    .service_pulse_in(svc), .watchdog_stop_n_in(stop_n), .sys_reset_n_out(rst_out),
    .wdog_active_out(act));
  srw_host u_host (.mclk_in(mclk), .run_in(run), .gap_in(16'h03e8),
    .service_pulse_out(svc));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic final_report();
    $display("mismatches %0d, checks %0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic check(input logic seen, input logic exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check
  // Counts falling edges until the reset output reaches lvl, bounded by max.
  task automatic wait_lvl(input logic lvl, input int max, output int cnt);
    cnt = 0;
    while (rst_out !== lvl && cnt < max) begin
      @(negedge mclk);
      cnt++;
    end
  endtask : wait_lvl
  function automatic logic in_rng(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi);
  endfunction : in_rng
  // A single service edge; the host keeps it the least legal width.
  task automatic one_service();
    run = 1'b1;
    repeat (5) @(negedge mclk);
    run = 1'b0;
  endtask : one_service
  // Reset the block with the supply low, then raise it.
  task automatic power_up(input logic stop);
    rst_n = 1'b0;
    sup_hi = 1'b0;
    sup_lo = 1'b1;
    stop_n = stop;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (20) @(negedge mclk);
    check(rst_out, 1'b0, "reset not held low at power-up");
    sup_lo = 1'b0;
    sup_hi = 1'b1;
  endtask : power_up
  task automatic t_power_on();
    power_up(1'b1);
    wait_lvl(1'b1, 20000, n);
    check(in_rng(n, 4995, 5010), 1'b1, "hold interval wrong");
    repeat (2) @(negedge mclk);
    check(act, 1'b1, "monitoring not started");
  endtask : t_power_on
  task automatic t_service_then_timeout();
    n = 0;
    run = 1'b1;
    for (int i = 0; i < 20000; i++) begin
      @(negedge mclk);
      if (rst_out !== 1'b1) n++;
    end
    run = 1'b0;
    check(in_rng(n, 0, 0), 1'b1, "reset during regular service");
    // Let the last regular discharge run out, or the next edge would be ignored.
    repeat (200) @(negedge mclk);
    one_service();
    wait_lvl(1'b0, 8000, n);
    check(in_rng(n, 5080, 5115), 1'b1, "timeout from last edge wrong");
    wait_lvl(1'b1, 300, n);
    check(in_rng(n, 97, 105), 1'b1, "watchdog reset width wrong");
  endtask : t_service_then_timeout
  task automatic t_dips();
    one_service();
    sup_lo = 1'b1;
    sup_hi = 1'b0;
    repeat (2) @(negedge mclk);
    check(rst_out, 1'b0, "short dip did not assert reset");
    sup_lo = 1'b0;
    sup_hi = 1'b1;
    wait_lvl(1'b1, 10, n);
    check(rst_out, 1'b1, "short dip restarted hold");
    sup_lo = 1'b1;
    sup_hi = 1'b0;
    repeat (300) @(negedge mclk);
    check(rst_out, 1'b0, "reset released while supply gone");
    sup_lo = 1'b0;
    sup_hi = 1'b1;
    wait_lvl(1'b1, 20000, n);
    check(in_rng(n, 4995, 5010), 1'b1, "hold after brownout wrong");
  endtask : t_dips
  task automatic t_stop();
    stop_n = 1'b0;
    n = 0;
    for (int i = 0; i < 12000; i++) begin
      @(negedge mclk);
      if (rst_out !== 1'b1) n++;
    end
    check(in_rng(n, 0, 0), 1'b1, "reset pulse while stopped");
    one_service();
    repeat (20) @(negedge mclk);
    stop_n = 1'b1;
    wait_lvl(1'b0, 3, n);
    check(rst_out, 1'b0, "no reset on release during discharge");
    wait_lvl(1'b1, 100, n);
    check(rst_out, 1'b1, "reset did not end with discharge");
    // The host services, lets that discharge run out, and only then releases stop.
    stop_n = 1'b0;
    one_service();
    repeat (150) @(negedge mclk);
    stop_n = 1'b1;
    repeat (3) @(negedge mclk);
    check(rst_out, 1'b1, "release after finished discharge gave reset");
  endtask : t_stop
  task automatic t_hold_variants();
    power_up(1'b0);
    wait_lvl(1'b1, 20000, n);
    check(in_rng(n, 4895, 4915), 1'b1, "stopped power-up hold wrong");
    power_up(1'b1);
    repeat (3000) @(negedge mclk);
    one_service();
    check(rst_out, 1'b0, "reset released early");
    wait_lvl(1'b1, 20000, n);
    check(in_rng(n, 4985, 5010), 1'b1, "hold not restarted by service");
  endtask : t_hold_variants
  // Cut a hang short after well over the expected run length.
  initial begin
    #1800000;
    n_fail++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    sup_hi = 1'b0;
    sup_lo = 1'b1;
    stop_n = 1'b1;
    run = 1'b0;
    @(negedge mclk);
    t_power_on();
    t_service_then_timeout();
    t_dips();
    t_stop();
    t_hold_variants();
    final_report();
  end
endmodule : testbench
`default_nettype wire
